// File: rtl/sms_defines.vh
// constants for the serial peripheral master/slave core
// included by rtl/sms_core.v and rtl/sms_shift.v; definitions only
`ifndef SMS_DEFINES_VH
`define SMS_DEFINES_VH

// register addresses on the 8-bit wishbone port
`define SMS_ADR_CTRL 3'h0
`define SMS_ADR_DIV 3'h1
`define SMS_ADR_CSN 3'h2
`define SMS_ADR_TXD 3'h3
`define SMS_ADR_RXD 3'h4
`define SMS_ADR_STAT 3'h5

// control register fields
`define SMS_CTRL_EN 0
`define SMS_CTRL_MST 1
`define SMS_CTRL_CPOL 2
`define SMS_CTRL_CPHA 3
`define SMS_CTRL_LSB 4
`define SMS_CTRL_IRQEN 5
`define SMS_CTRL_STDBY 6

// status register fields
`define SMS_ST_TXE 0
`define SMS_ST_RXF 1
`define SMS_ST_BUSY 2
`define SMS_ST_MODF 3
`define SMS_ST_OVR 4

// reset values
`define SMS_CTRL_RST 7'h00
`define SMS_DIV_RST 8'h03
`define SMS_CSN_RST 8'hff
`define SMS_SYNC_RST 5'h18

// bits per serial byte
`define SMS_BITS 4'h8

`endif

// File: rtl/sms_shift.v
// byte shifter shared by master and slave operation
// assumes one-cycle lead and trail edge pulses on the core clock
`timescale 1ns/100ps
`include "sms_defines.vh"

module sms_shift (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_load,
  input wire [7:0] i_tx,
  input wire i_lsb_first,
  input wire i_cpha,
  input wire i_lead,
  input wire i_trail,
  input wire i_sdi,
  output reg o_sdo,
  output reg [7:0] o_rx,
  output reg o_done
);

  reg [7:0] sh_q;
  reg [3:0] cnt_q;
  wire smp;
  wire shf;

  // first bit on the line for the chosen order
  function head;
    input [7:0] v;
    input lsb;
    begin
      head = lsb ? v[0] : v[7];
    end
  endfunction

  // advance a byte one place, filling with b
  function [7:0] adv;
    input [7:0] v;
    input lsb;
    input b;
    begin
      adv = lsb ? {b, v[7:1]} : {v[6:0], b};
    end
  endfunction

  // phase picks which edge samples and which edge shifts
  assign smp = i_cpha ? i_trail : i_lead;
  assign shf = i_cpha ? i_lead : i_trail;

  // full duplex: one bit out and one bit in per clock cycle
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      o_sdo <= 1'b0;
      o_rx <= 8'h00;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_load) begin
        cnt_q <= 4'h0;
        sh_q <= i_cpha ? i_tx : adv(i_tx, i_lsb_first, 1'b0);
        if (!i_cpha) begin
          o_sdo <= head(i_tx, i_lsb_first);
        end
      end else begin
        if (cnt_q != `SMS_BITS) begin
          if (shf) begin
            o_sdo <= head(sh_q, i_lsb_first);
            sh_q <= adv(sh_q, i_lsb_first, 1'b0);
          end
          if (smp) begin
            o_rx <= adv(o_rx, i_lsb_first, i_sdi);
            cnt_q <= cnt_q + 4'h1;
          end
        end
        // last trailing edge ends the byte, even once the count is full
        if (i_trail && (cnt_q == (i_cpha ? `SMS_BITS - 4'h1 : `SMS_BITS))) begin
          o_done <= 1'b1;
        end
      end
    end
  end

endmodule // sms_shift

// File: rtl/sms_core.v
// serial peripheral core, master or slave, behind an 8-bit wishbone port
// assumes wishbone signals on I_CORE_CLK; serial pins are asynchronous
`timescale 1ns/100ps
`include "sms_defines.vh"

module sms_core #(
  parameter [0:0] WAKEUP_EN = 1'b0
) (
  input wire I_CORE_CLK,
  input wire I_RST_N,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [2:0] I_WB_ADR,
  input wire [7:0] I_WB_DAT,
  output reg [7:0] O_WB_DAT,
  output reg O_WB_ACK,
  input wire I_SPI_CLK,
  output reg O_SPI_CLK,
  output reg O_SPI_CLK_OE,
  input wire I_SPI_MISO,
  output reg O_SPI_MISO,
  output reg O_SPI_MISO_OE,
  input wire I_SPI_MOSI,
  output reg O_SPI_MOSI,
  output reg O_SPI_MOSI_OE,
  output reg [7:0] O_SPI_CSN,
  input wire I_SPI_SCSN,
  input wire I_CONFIG_PORT_SELECT_N,
  output reg O_SPI_IRQ,
  output reg O_CFG_STDBY,
  output reg O_CFG_WAKE
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_RUN = 2'd1;
  localparam [1:0] ST_GAP = 2'd2;
  localparam [4:0] SYNC_RST = `SMS_SYNC_RST;

  wire [4:0] pin_raw;
  wire [4:0] pin_s;
  wire sclk_s;
  wire miso_s;
  wire mosi_s;
  wire scsn_s;
  wire cfg_sel_n_s;
  reg [6:0] ctrl_q;
  reg [7:0] div_q;
  reg [7:0] csn_q;
  reg [7:0] tx_q;
  reg tx_full_q;
  reg [7:0] rx_q;
  reg rx_full_q;
  reg modf_q;
  reg ovr_q;
  reg [1:0] st_q;
  reg [7:0] div_cnt_q;
  reg sclk_q;
  reg [2:0] tcnt_q;
  reg sclk_prev_q;
  reg sel_prev_q;
  reg [7:0] rd_d;
  wire acc;
  wire wr;
  wire rd;
  wire enable;
  wire mst;
  wire cpol;
  wire tick;
  wire m_lead;
  wire m_trail;
  wire s_active;
  wire s_start;
  wire s_edge;
  wire s_lead;
  wire s_trail;
  wire lead;
  wire trail;
  wire done;
  wire sdo;
  wire [7:0] rx_byte;
  wire m_load;
  wire s_load;
  wire load;
  wire modf_set;
  wire busy;

  // two-flop synchronisers for every pin input
  assign pin_raw = {I_CONFIG_PORT_SELECT_N, I_SPI_SCSN, I_SPI_MOSI, I_SPI_MISO, I_SPI_CLK};
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_sync
      reg meta_q;
      reg sync_q;
      always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
          meta_q <= SYNC_RST[g];
          sync_q <= SYNC_RST[g];
        end else begin
          meta_q <= pin_raw[g];
          sync_q <= meta_q;
        end
      end
      assign pin_s[g] = sync_q;
    end
  endgenerate
  assign sclk_s = pin_s[0];
  assign miso_s = pin_s[1];
  assign mosi_s = pin_s[2];
  assign scsn_s = pin_s[3];
  assign cfg_sel_n_s = pin_s[4];

  // wishbone handshake: one access per request, ack one cycle later
  assign acc = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  assign wr = acc & I_WB_WE;
  assign rd = acc & ~I_WB_WE;

  // mode decode
  assign enable = ctrl_q[`SMS_CTRL_EN];
  assign mst = enable & ctrl_q[`SMS_CTRL_MST];
  assign cpol = ctrl_q[`SMS_CTRL_CPOL];

  // master clock generation from the half-period divider
  assign tick = (st_q == ST_RUN) && (div_cnt_q == div_q);
  assign m_lead = tick & (sclk_q == cpol);
  assign m_trail = tick & (sclk_q != cpol);

  // slave selected only when the config select is idle
  assign s_active = enable & ~ctrl_q[`SMS_CTRL_MST] & ~scsn_s & cfg_sel_n_s;
  assign s_start = s_active & ~sel_prev_q;
  assign s_edge = s_active & (sclk_s ^ sclk_prev_q);
  assign s_lead = s_edge & (sclk_prev_q == cpol);
  assign s_trail = s_edge & (sclk_prev_q != cpol);

  // edge and data routing by mode
  assign lead = mst ? m_lead : s_lead;
  assign trail = mst ? m_trail : s_trail;
  assign m_load = mst & tx_full_q & ((st_q == ST_IDLE) | ((st_q == ST_GAP) & done));
  assign s_load = s_start | (s_active & done);
  assign load = m_load | s_load;

  // a second master pulling the select low while we are master
  assign modf_set = mst & ~scsn_s;
  assign busy = (st_q != ST_IDLE) | s_active;

  sms_shift u_shift (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_load(load),
    .i_tx(tx_q),
    .i_lsb_first(ctrl_q[`SMS_CTRL_LSB]),
    .i_cpha(ctrl_q[`SMS_CTRL_CPHA]),
    .i_lead(lead),
    .i_trail(trail),
    .i_sdi(mst ? miso_s : mosi_s),
    .o_sdo(sdo),
    .o_rx(rx_byte),
    .o_done(done)
  );

  // register read mux
  always @* begin
    case (I_WB_ADR)
      `SMS_ADR_CTRL: rd_d = {1'b0, ctrl_q};
      `SMS_ADR_DIV: rd_d = div_q;
      `SMS_ADR_CSN: rd_d = csn_q;
      `SMS_ADR_TXD: rd_d = tx_q;
      `SMS_ADR_RXD: rd_d = rx_q;
      `SMS_ADR_STAT: rd_d = {3'h0, ovr_q, modf_q, busy, rx_full_q, ~tx_full_q};
      default: rd_d = 8'h00;
    endcase
  end

  // wishbone slave and software-visible registers
  always @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 8'h00;
      ctrl_q <= `SMS_CTRL_RST;
      div_q <= `SMS_DIV_RST;
      csn_q <= `SMS_CSN_RST;
      tx_q <= 8'h00;
      tx_full_q <= 1'b0;
      rx_q <= 8'h00;
      rx_full_q <= 1'b0;
      modf_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      O_WB_ACK <= acc;
      O_WB_DAT <= rd ? rd_d : 8'h00;
      if (wr && I_WB_ADR == `SMS_ADR_CTRL) begin
        ctrl_q <= I_WB_DAT[6:0];
      end
      if (modf_set) begin
        ctrl_q[`SMS_CTRL_MST] <= 1'b0;
      end
      if (wr && I_WB_ADR == `SMS_ADR_DIV) begin
        div_q <= I_WB_DAT;
      end
      if (wr && I_WB_ADR == `SMS_ADR_CSN) begin
        csn_q <= I_WB_DAT;
      end
      // transmit holding byte, set wins over the take
      if (wr && I_WB_ADR == `SMS_ADR_TXD) begin
        tx_q <= I_WB_DAT;
        tx_full_q <= 1'b1;
      end else if (load) begin
        tx_full_q <= 1'b0;
      end
      // receive holding byte, new data wins over the read clear
      if (done) begin
        rx_q <= rx_byte;
        rx_full_q <= 1'b1;
        if (rx_full_q && !(rd && I_WB_ADR == `SMS_ADR_RXD)) begin
          ovr_q <= 1'b1;
        end
      end else if (rd && I_WB_ADR == `SMS_ADR_RXD) begin
        rx_full_q <= 1'b0;
      end
      // sticky error flags, write one to clear, set wins
      if (modf_set) begin
        modf_q <= 1'b1;
      end else if (wr && I_WB_ADR == `SMS_ADR_STAT && I_WB_DAT[`SMS_ST_MODF]) begin
        modf_q <= 1'b0;
      end
      if (wr && I_WB_ADR == `SMS_ADR_STAT && I_WB_DAT[`SMS_ST_OVR] && !(done && rx_full_q)) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // master sequencer: run eight clocks, then pause for the next byte
  always @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q <= ST_IDLE;
      div_cnt_q <= 8'h00;
      sclk_q <= 1'b0;
      tcnt_q <= 3'h0;
    end else if (!mst) begin
      st_q <= ST_IDLE;
      div_cnt_q <= 8'h00;
      sclk_q <= cpol;
      tcnt_q <= 3'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          sclk_q <= cpol;
          div_cnt_q <= 8'h00;
          tcnt_q <= 3'h0;
          if (m_load) begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (tick) begin
            div_cnt_q <= 8'h00;
            sclk_q <= ~sclk_q;
            if (m_trail) begin
              tcnt_q <= tcnt_q + 3'h1;
              if (tcnt_q == 3'h7) begin
                st_q <= ST_GAP;
              end
            end
          end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
          end
        end
        ST_GAP: begin
          div_cnt_q <= 8'h00;
          if (done) begin
            st_q <= m_load ? ST_RUN : ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // slave edge history
  always @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sclk_prev_q <= 1'b0;
      sel_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      sel_prev_q <= s_active;
    end
  end

  // pin drivers and side outputs, all registered
  always @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_SPI_CLK <= 1'b0;
      O_SPI_CLK_OE <= 1'b0;
      O_SPI_MOSI <= 1'b0;
      O_SPI_MOSI_OE <= 1'b0;
      O_SPI_MISO <= 1'b0;
      O_SPI_MISO_OE <= 1'b0;
      O_SPI_CSN <= `SMS_CSN_RST;
      O_SPI_IRQ <= 1'b0;
      O_CFG_STDBY <= 1'b0;
      O_CFG_WAKE <= 1'b0;
    end else begin
      O_SPI_CLK <= sclk_q;
      O_SPI_CLK_OE <= mst;
      O_SPI_MOSI <= mst ? sdo : 1'b0;
      O_SPI_MOSI_OE <= mst;
      O_SPI_MISO <= s_active ? sdo : 1'b0;
      O_SPI_MISO_OE <= s_active;
      O_SPI_CSN <= mst ? csn_q : `SMS_CSN_RST;
      O_SPI_IRQ <= modf_q & ctrl_q[`SMS_CTRL_IRQEN];
      O_CFG_STDBY <= WAKEUP_EN & ctrl_q[`SMS_CTRL_STDBY];
      O_CFG_WAKE <= WAKEUP_EN & ctrl_q[`SMS_CTRL_STDBY] & s_start;
    end
  end

endmodule // sms_core

// File: sim/sms_core_monitor.sv
// port-level checks on sms_core
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/100ps
module sms_core_monitor #(
  parameter [0:0] WAKEUP_EN = 1'b0
) (
  input wire I_CORE_CLK,
  input wire I_RST_N,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire [7:0] O_WB_DAT,
  input wire O_WB_ACK,
  input wire O_SPI_CLK_OE,
  input wire O_SPI_MISO,
  input wire O_SPI_MISO_OE,
  input wire I_SPI_SCSN,
  input wire I_CONFIG_PORT_SELECT_N,
  input wire O_CFG_STDBY,
  input wire O_CFG_WAKE
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  // select pulled low while driving the clock
  sequence s_master_hit;
    O_SPI_CLK_OE ##1 !I_SPI_SCSN [*3];
  endsequence
  // clock driver let go soon after
  sequence s_released;
    ##[0:6] !O_SPI_CLK_OE;
  endsequence
  AST_ACK_TAKE: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("request not acknowledged one cycle later");
  AST_DAT_IDLE: assert property (!O_WB_ACK |-> O_WB_DAT == 8'h00)
    else $error("read data not zero outside ack");
  AST_FAULT: assert property (s_master_hit |-> s_released)
    else $error("clock still driven after mode fault");
  AST_OE_EXCL: assert property (!(O_SPI_CLK_OE && O_SPI_MISO_OE))
    else $error("master and slave drivers both on");
  AST_CFG_SEL: assert property (!I_CONFIG_PORT_SELECT_N [*6] |-> !O_SPI_MISO_OE)
    else $error("slave driving while config select low");
  AST_SLV_SEL: assert property (I_SPI_SCSN [*6] |-> !O_SPI_MISO_OE)
    else $error("slave driving while not selected");
  AST_MISO_IDLE: assert property (!O_SPI_MISO_OE && $past(!O_SPI_MISO_OE) |-> !O_SPI_MISO)
    else $error("slave data not low while released");
  AST_WAKE_OFF: assert property (WAKEUP_EN == 1'b0 |-> !O_CFG_STDBY && !O_CFG_WAKE)
    else $error("standby or wake active without wake option");
endmodule // sms_core_monitor

bind sms_core sms_core_monitor #(.WAKEUP_EN(WAKEUP_EN)) sms_core_monitor_inst (
  .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
  .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_SPI_CLK_OE(O_SPI_CLK_OE),
  .O_SPI_MISO(O_SPI_MISO), .O_SPI_MISO_OE(O_SPI_MISO_OE), .I_SPI_SCSN(I_SPI_SCSN),
  .I_CONFIG_PORT_SELECT_N(I_CONFIG_PORT_SELECT_N), .O_CFG_STDBY(O_CFG_STDBY),
  .O_CFG_WAKE(O_CFG_WAKE));

// File: sim/sms_spi_peer.sv
// behavioural serial slave answering the core as master
// assumes mode inputs are settled before select falls
`timescale 1ns/100ps
module sms_spi_peer (
  input wire i_sck,
  input wire i_csn,
  input wire i_mosi,
  input wire i_cpol,
  input wire i_cpha,
  input wire i_lsb,
  input wire [7:0] i_tx,
  output reg o_miso,
  output reg [7:0] o_rx
);
  integer ni = 0;
  integer no = 0;
  // bit position of the k-th bit on the wire
  function integer idx(input integer k);
    idx = i_lsb ? k : 7 - k;
  endfunction
  // first bit ready at select when sampling on the leading edge
  always @(negedge i_csn) begin
    ni = 0;
    no = i_cpha ? 0 : 1;
    if (!i_cpha) o_miso = i_tx[idx(0)];
  end
  // released line shows the inverse of its last bit
  always @(posedge i_csn) o_miso = ~o_miso;
  // one bit in and one bit out per clock cycle
  always @(i_sck) begin
    if (!i_csn) begin
      if ((i_sck !== i_cpol) ^ i_cpha) begin
        if (ni < 8) o_rx[idx(ni)] = i_mosi;
        ni = ni + 1;
      end else if (no < 8) begin
        o_miso = i_tx[idx(no)];
        no = no + 1;
      end
    end
  end
endmodule // sms_spi_peer

// File: sim/sms_core_tb.sv
// self-checking bench for sms_core with a serial peer
// assumes the peer model and the monitor are compiled first
`timescale 1ns/100ps
module sms_core_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg [2:0] adr = 3'h0;
  reg [7:0] wdat = 8'h00;
  reg scsn = 1'b1, cfg_n = 1'b1, t_sck = 1'b0, t_mosi = 1'b0;
  reg cp = 1'b0, ph = 1'b0, lb = 1'b0;
  reg [7:0] ptx = 8'h00, tx, sb;
  reg [31:0] rnd = 32'h970b1b53;
  reg [11:0] q [$];
  reg [11:0] e;
  integer n_mismatch = 0, checked = 0, m, i;
  wire [7:0] rdat, csn, prx;
  wire ack, sck_o, sck_oe, miso_o, miso_oe, mosi_o, mosi_oe, irq, stdby, wake, pmiso;
  // pin levels resolved from the drivers' enables
  wire sck = sck_oe ? sck_o : t_sck;
  wire miso = miso_oe ? miso_o : pmiso;
  wire mosi = mosi_oe ? mosi_o : t_mosi;
  sms_core sms_core_inst (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_SPI_CLK(sck), .O_SPI_CLK(sck_o), .O_SPI_CLK_OE(sck_oe), .I_SPI_MISO(miso),
    .O_SPI_MISO(miso_o), .O_SPI_MISO_OE(miso_oe), .I_SPI_MOSI(mosi), .O_SPI_MOSI(mosi_o),
    .O_SPI_MOSI_OE(mosi_oe), .O_SPI_CSN(csn), .I_SPI_SCSN(scsn),
    .I_CONFIG_PORT_SELECT_N(cfg_n), .O_SPI_IRQ(irq), .O_CFG_STDBY(stdby), .O_CFG_WAKE(wake));
  sms_spi_peer sms_spi_peer_inst (.i_sck(sck), .i_csn(&csn), .i_mosi(mosi), .i_cpol(cp),
    .i_cpha(ph), .i_lsb(lb), .i_tx(ptx), .o_miso(pmiso), .o_rx(prx));
  // 100 MHz core clock
  initial begin
    forever #5 clk = ~clk;
  end
  // xorshift step for random bytes
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // one comparison, reported at once on a miss
  task chk(input [8*8-1:0] nm, input [7:0] exp, input [7:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // one bus access; a read notes its expected byte
  task wb(input w, input [2:0] a, input [7:0] d);
    integer n;
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      q.push_back({~w, a, d});
      n = 0;
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      chk("ack", 8'h01, {7'h0, ack});
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  // compare each acknowledged read with the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      if (e[11]) chk({"rd", 8'h30 + e[10:8]}, e[7:0], rdat);
    end
  end
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // watchdog at 200 us, over ten times the expected run of about 12 us
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wb(0, 3'h0, 8'h00);
    wb(0, 3'h1, 8'h03);
    wb(0, 3'h2, 8'hff);
    wb(1, 3'h7, 8'h5a);
    wb(0, 3'h7, 8'h00);
    $display("test reset done");
    for (m = 0; m < 8; m = m + 1) begin
      rnd = xs(rnd);
      {cp, ph, lb} = m[2:0];
      ptx = rnd[15:8];
      tx = rnd[7:0];
      wb(1, 3'h0, {3'h0, lb, ph, cp, 2'h3});
      wb(1, 3'h2, ~(8'h01 << m));
      repeat (2) @(negedge clk);
      chk("csn", ~(8'h01 << m), csn);
      wb(1, 3'h3, tx);
      repeat (100) @(posedge clk);
      wb(0, 3'h4, ptx);
      chk("peer", tx, prx);
      wb(1, 3'h2, 8'hff);
    end
    $display("test master done");
    cfg_n <= 1'b0;
    wb(1, 3'h0, 8'h23);
    scsn <= 1'b0;
    repeat (8) @(posedge clk);
    scsn <= 1'b1;
    repeat (4) @(negedge clk);
    chk("irq", 8'h01, {7'h0, irq});
    wb(0, 3'h0, 8'h21);
    wb(0, 3'h5, 8'h09);
    wb(1, 3'h5, 8'h08);
    repeat (3) @(negedge clk);
    chk("irq", 8'h00, {7'h0, irq});
    $display("test fault done");
    wb(1, 3'h0, 8'h41);
    rnd = xs(rnd);
    wb(1, 3'h3, rnd[7:0]);
    scsn <= 1'b0;
    repeat (10) @(negedge clk);
    chk("oe_cfg", 8'h00, {7'h0, miso_oe});
    @(posedge clk);
    cfg_n <= 1'b1;
    repeat (10) @(negedge clk);
    chk("oe_sel", 8'h01, {7'h0, miso_oe});
    for (i = 7; i >= 0; i = i - 1) begin
      @(posedge clk);
      t_mosi <= rnd[8 + i];
      repeat (8) @(posedge clk);
      t_sck <= 1'b1;
      sb[i] = miso;
      repeat (7) @(posedge clk);
      t_sck <= 1'b0;
    end
    repeat (8) @(posedge clk);
    scsn <= 1'b1;
    repeat (8) @(posedge clk);
    chk("miso", rnd[7:0], sb);
    wb(0, 3'h4, rnd[15:8]);
    chk("stdby", 8'h00, {6'h0, stdby, wake});
    $display("test slave done");
    final_report;
  end
endmodule // sms_core_tb
